// ===== common/light_prox_pkg.sv
// Purpose: constants and carriers for the light and proximity register block
// Assumes: byte-wide register port, 20 MHz clock
// Notes:   part code value is arbitrary
package light_prox_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_PULSE_COUNT = 8'h0E;
  localparam logic [7:0] ADDR_ANALOG_CTRL = 8'h0F;
  localparam logic [7:0] ADDR_PART_ID     = 8'h12;
  localparam logic [7:0] ADDR_STATUS      = 8'h13;
  localparam logic [7:0] ADDR_CLEAR_LOW   = 8'h14;
  localparam logic [7:0] ADDR_CLEAR_HIGH  = 8'h15;
  localparam logic [7:0] ADDR_IR_LOW      = 8'h16;
  localparam logic [7:0] ADDR_IR_HIGH     = 8'h17;
  localparam logic [7:0] ADDR_PROX_LOW    = 8'h18;
  localparam logic [7:0] ADDR_PROX_HIGH   = 8'h19;
  // ----------------------------------------
  // fields, resets, identity
  // ----------------------------------------
  localparam int         STAT_NEAR_BIT    = 5;
  localparam int         STAT_LIGHT_BIT   = 4;
  localparam int         STAT_VALID_BIT   = 0;
  localparam logic [7:0] PULSE_RESET      = 8'h00;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK  = 8'hF3;
  // arbitrary neutral part code
  localparam logic [7:0] PART_CODE        = 8'h5A;
  // ----------------------------------------
  // timing: pulse rate 62.5 kHz at 20 MHz
  // ----------------------------------------
  localparam int         CLOCK_HZ         = 20000000;
  localparam int         PULSE_RATE_HZ    = 62500;
  localparam int         PULSE_PERIOD_CYC = CLOCK_HZ / PULSE_RATE_HZ;
  localparam int         PULSE_HIGH_CYC   = PULSE_PERIOD_CYC / 2;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] drive;
    logic [1:0] diode;
    logic [1:0] gain;
  } analog_ctrl_type;
  typedef struct packed {
    logic [15:0] clear_val;
    logic [15:0] ir_val;
  } light_result_type;
endpackage

// ===== rtl/light_prox_sensor_regs.sv
// Purpose: register file, shadow reads and proximity pulse sequencing
// Assumes: serial front end gives byte reads/writes with one-cycle strobes
// Notes:   analog settings leave as decoded codes for the analog block
//
// Contract
// - each proximity measurement emits the programmed number of LED pulses.
// - pulses run at a fixed 62.5 kHz rate.
// - one proximity cycle follows each light integration completed while idle, when enabled and the pulse count is nonzero.
// - light integration timing spaces proximity events even with light sensing off.
// - an 8-bit read-only part identification value is readable.
// - status bit 5 shows proximity interrupt active.
// - status bit 4 shows light interrupt active.
// - status bit 0 sets once clear and infrared integration completes.
// - clear and infrared results read as 16-bit low/high byte pairs.
// - reading a low byte latches its high byte into a shadow.
// - light shadow stays unchanged when new integrations complete.
// - proximity result 16-bit at 0x18/0x19, low read latches high.
// - proximity shadow stays intact across a new conversion.
`timescale 1ns/10ps
module light_prox_sensor_regs (
  input  wire logic                             clock,
  input  wire logic                             rst,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  input  wire logic [7:0]                       reg_addr,
  input  wire logic [7:0]                       reg_wdata,
  output logic      [7:0]                       reg_rdata,
  input  wire logic                             prox_enable,
  input  wire logic                             integ_done,
  input  wire light_prox_pkg::light_result_type light_result,
  input  wire logic                             light_result_load,
  input  wire logic [15:0]                      prox_result,
  input  wire logic                             prox_result_load,
  input  wire logic                             near_irq_flag,
  input  wire logic                             light_irq_flag,
  input  wire logic                             valid_clear,
  output light_prox_pkg::analog_ctrl_type       analog_ctrl,
  output logic [7:0]                            led_pulse,
  output logic                                  prox_busy,
  output logic                                  prox_done
);
  import light_prox_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    PX_IDLE  = 2'b01,
    PX_PULSE = 2'b10
  } prox_state_type;

  prox_state_type   state_q, state_d;
  logic [7:0]       pulse_count_q;
  logic [7:0]       ctrl_q;
  logic [7:0]       pulse_left_q;
  logic [8:0]       tick_q;
  logic             led_q;
  logic             done_q;
  logic             valid_q;
  logic             near_s1_q, near_s2_q, light_s1_q, light_s2_q;
  light_result_type result_q;
  logic [15:0]      prox_q;
  logic [7:0]       clear_shadow_q, ir_shadow_q, prox_shadow_q;
  logic [7:0]       rdata_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  wire  wr_pulse   = reg_wr && hit(reg_addr, ADDR_PULSE_COUNT);
  wire  wr_ctrl    = reg_wr && hit(reg_addr, ADDR_ANALOG_CTRL);
  wire  rd_clear_l = reg_rd && hit(reg_addr, ADDR_CLEAR_LOW);
  wire  rd_ir_l    = reg_rd && hit(reg_addr, ADDR_IR_LOW);
  wire  rd_prox_l  = reg_rd && hit(reg_addr, ADDR_PROX_LOW);
  function automatic logic [8:0] tick_after(input logic [8:0] t, input logic wrap);
    return wrap ? 9'h000 : t + 9'h001;
  endfunction

  function automatic logic led_level(input logic [8:0] t);
    return t < 9'(PULSE_HIGH_CYC);
  endfunction

  wire        period_end  = (tick_q == 9'(PULSE_PERIOD_CYC - 1));
  wire        last_pulse  = period_end && (pulse_left_q == 8'h01);
  wire        start_prox  = integ_done && prox_enable && (state_q == PX_IDLE);
  wire        have_pulses = (pulse_count_q != 8'h00);
  wire        start_train = start_prox && have_pulses;
  wire        in_train    = (state_q == PX_PULSE);
  wire  [8:0] tick_next   = tick_after(tick_q, period_end);
  wire        led_next    = !last_pulse && led_level(tick_next);
  logic [7:0] status_word;
  logic [7:0] rd_mux;

  // ----------------------------------------
  // status and outputs
  // ----------------------------------------
  // status word: near, light and valid bits
  always_comb begin
    status_word                 = 8'h00;
    status_word[STAT_NEAR_BIT]  = near_s2_q;
    status_word[STAT_LIGHT_BIT] = light_s2_q;
    status_word[STAT_VALID_BIT] = valid_q;
  end

  assign analog_ctrl = '{drive: ctrl_q[7:6], diode: ctrl_q[5:4], gain: ctrl_q[1:0]};
  assign led_pulse   = {7'h00, led_q};
  assign prox_busy   = (state_q == PX_PULSE);
  assign prox_done   = done_q;
  assign reg_rdata   = rdata_q;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // register read multiplexer
  always_comb begin
    unique case (reg_addr)
      ADDR_PULSE_COUNT: rd_mux = pulse_count_q;
      ADDR_ANALOG_CTRL: rd_mux = ctrl_q & CTRL_WRITE_MASK;
      ADDR_PART_ID:     rd_mux = PART_CODE;
      ADDR_STATUS:      rd_mux = status_word;
      ADDR_CLEAR_LOW:   rd_mux = result_q.clear_val[7:0];
      ADDR_CLEAR_HIGH:  rd_mux = clear_shadow_q;
      ADDR_IR_LOW:      rd_mux = result_q.ir_val[7:0];
      ADDR_IR_HIGH:     rd_mux = ir_shadow_q;
      ADDR_PROX_LOW:    rd_mux = prox_q[7:0];
      ADDR_PROX_HIGH:   rd_mux = prox_shadow_q;
      default:          rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------
  // pulse state
  // ----------------------------------------
  // start after integration
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PX_IDLE: begin
        if (start_train) begin
          state_d = PX_PULSE;
        end
      end
      PX_PULSE: begin
        if (last_pulse) begin
          state_d = PX_IDLE;
        end
      end
      default: state_d = PX_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // only writable locations decode
  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_count_q <= PULSE_RESET;
    end else begin
      if (wr_pulse) begin
        pulse_count_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata & CTRL_WRITE_MASK;
      end
    end
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // holds between reads so a slow host sees a stable byte
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // flags arrive from the interrupt logic outside
  // only the second stage is read; the first may be metastable
  always_ff @(posedge clock) begin
    if (rst) begin
      near_s1_q <= 1'b0;
      near_s2_q <= 1'b0;
    end else begin
      near_s1_q <= near_irq_flag;
      near_s2_q <= near_s1_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      light_s1_q <= 1'b0;
      light_s2_q <= 1'b0;
    end else begin
      light_s1_q <= light_irq_flag;
      light_s2_q <= light_s1_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else if (light_result_load) begin
      valid_q <= 1'b1;
    end else if (valid_clear) begin
      valid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // results and shadows
  // ----------------------------------------
  // live results track conversions; shadows change only on low reads
  always_ff @(posedge clock) begin
    if (rst) begin
      result_q <= '0;
    end else if (light_result_load) begin
      result_q <= light_result;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prox_q <= 16'h0000;
    end else if (prox_result_load) begin
      prox_q <= prox_result;
    end
  end

  // a later load never touches the shadows
  // latch on low read
  always_ff @(posedge clock) begin
    if (rst) begin
      clear_shadow_q <= 8'h00;
    end else if (rd_clear_l) begin
      clear_shadow_q <= result_q.clear_val[15:8];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ir_shadow_q <= 8'h00;
    end else if (rd_ir_l) begin
      ir_shadow_q <= result_q.ir_val[15:8];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prox_shadow_q <= 8'h00;
    end else if (rd_prox_l) begin
      prox_shadow_q <= prox_q[15:8];
    end
  end

  // ----------------------------------------
  // pulse sequencer
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= PX_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // done trails the last period by one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= in_train && last_pulse;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_left_q <= 8'h00;
    end else if (!in_train) begin
      pulse_left_q <= pulse_count_q;
    end else if (period_end) begin
      pulse_left_q <= pulse_left_q - 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tick_q <= 9'h000;
    end else if (!in_train) begin
      tick_q <= 9'h000;
    end else begin
      tick_q <= tick_next;
    end
  end

  // fixed high time
  // idle raises the led at once so the first pulse is full width
  always_ff @(posedge clock) begin
    if (rst) begin
      led_q <= 1'b0;
    end else if (!in_train) begin
      led_q <= start_train;
    end else begin
      led_q <= led_next;
    end
  end

endmodule // light_prox_sensor_regs

// ===== sim/light_prox_host.sv
// Purpose: host side of the byte register port
// Assumes: one access at a time
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/10ps
module light_prox_host (
  input  wire logic       clock,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // light_prox_host

// ===== sim/light_prox_sensor_regs_assertions.sv
// Purpose: port checks of the register block
// Assumes: synchronous active-high reset
// Notes:   pulse period is measured by the bench
`timescale 1ns/10ps
module light_prox_sensor_regs_assertions (
  input wire logic                            clock,
  input wire logic                            rst,
  input wire logic                            reg_wr,
  input wire logic                            reg_rd,
  input wire logic [7:0]                      reg_addr,
  input wire logic [7:0]                      reg_wdata,
  input wire logic [7:0]                      reg_rdata,
  input wire logic                            prox_enable,
  input wire logic                            integ_done,
  input wire light_prox_pkg::analog_ctrl_type analog_ctrl,
  input wire logic [7:0]                      led_pulse,
  input wire logic                            prox_busy,
  input wire logic                            prox_done
);
  import light_prox_pkg::*;
  logic [7:0] wd_q;
  always_ff @(posedge clock) wd_q <= reg_wdata;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_led_on; ##159 led_pulse[0] ##1 !led_pulse[0]; endsequence
  property p_part; reg_rd && reg_addr == ADDR_PART_ID |=> reg_rdata == PART_CODE; endproperty
  a_part: assert property (p_part) else $error("part code wrong");
  property p_ctrl; reg_wr && reg_addr == ADDR_ANALOG_CTRL |=>
    analog_ctrl == {wd_q[7:4], wd_q[1:0]}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("analog fields wrong");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_start; $rose(prox_busy) |-> $past(integ_done) && $past(prox_enable); endproperty
  a_start: assert property (p_start) else $error("cycle started alone");
  property p_on; $rose(led_pulse[0]) |-> s_led_on; endproperty
  a_on: assert property (p_on) else $error("pulse width wrong");
  property p_done; prox_done |-> !led_pulse[0] ##1 !prox_done; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_led; led_pulse[0] |-> prox_busy; endproperty
  a_led: assert property (p_led) else $error("pulse outside cycle");
  property p_rsvd; led_pulse[7:1] == 7'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("spare pulse bits set");
endmodule // light_prox_sensor_regs_assertions
bind light_prox_sensor_regs light_prox_sensor_regs_assertions u_chk (.clock(clock),
  .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .prox_enable(prox_enable),
  .integ_done(integ_done), .analog_ctrl(analog_ctrl), .led_pulse(led_pulse),
  .prox_busy(prox_busy), .prox_done(prox_done));

// ===== sim/light_prox_sensor_regs_tb_top.sv
// Purpose: self-checking bench of the register block
// Assumes: host model owns the register port
// Notes:   short pulse count keeps the run brief
`timescale 1ns/10ps
module light_prox_sensor_regs_tb_top;
  import light_prox_pkg::*;
  logic clock, rst, reg_wr, reg_rd, prox_enable, integ_done, light_result_load;
  logic prox_result_load, near_irq_flag, light_irq_flag, valid_clear, prox_busy, prox_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, led_pulse, d;
  logic [15:0] prox_result;
  logic [31:0] seed = 32'hEECD_9F5C;
  light_result_type light_result;
  analog_ctrl_type analog_ctrl;
  int n_errors, total_checks, pulse_m, ctrl_m, near_m, light_m, valid_m, n, per, t0, pv;
  int res_m[3], shd_m[3];
  light_prox_sensor_regs u_light_prox_sensor_regs (.clock, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .prox_enable, .integ_done, .light_result,
    .light_result_load, .prox_result, .prox_result_load, .near_irq_flag,
    .light_irq_flag, .valid_clear, .analog_ctrl, .led_pulse, .prox_busy, .prox_done);
  light_prox_host u_light_prox_host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reference register map
  function automatic int exp_rd(int a);
    int k;
    k = (a - ADDR_CLEAR_LOW) / 2;
    case (a)
      ADDR_PULSE_COUNT: return pulse_m;
      ADDR_ANALOG_CTRL: return ctrl_m & CTRL_WRITE_MASK;
      ADDR_PART_ID:     return PART_CODE;
      ADDR_STATUS:      return near_m * 32 + light_m * 16 + valid_m;
      ADDR_CLEAR_LOW, ADDR_IR_LOW, ADDR_PROX_LOW: begin
        shd_m[k] = res_m[k] >> 8;
        return res_m[k] & 255;
      end
      ADDR_CLEAR_HIGH, ADDR_IR_HIGH, ADDR_PROX_HIGH: return shd_m[k];
      default:          return 0;
    endcase
  endfunction
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic rchk(logic [7:0] a);
    u_light_prox_host.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, d}, 16'(exp_rd(a)));
  endtask
  task automatic ld();
    seed = lfsr(seed);
    @(posedge clock);
    light_result <= seed;
    prox_result <= seed[23:8];
    {light_result_load, prox_result_load, integ_done} <= 3'b111;
    res_m = '{int'(seed[31:16]), int'(seed[15:0]), int'(seed[23:8])};
    valid_m = 1;
    @(posedge clock);
    {light_result_load, prox_result_load, integ_done} <= 3'b000;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    {rst, prox_enable, integ_done, light_result_load, prox_result_load} = 5'b10000;
    {near_irq_flag, light_irq_flag, valid_clear, light_result, prox_result} = '0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    foreach (res_m[i]) {res_m[i], shd_m[i]} = '0;
    for (int a = 8'h0E; a <= 8'h1A; a++) rchk(8'(a));
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ctrl_m = i * 8'h51 | (seed[7:0] & 8'h0C);
      pulse_m = seed[15:8];
      u_light_prox_host.wr(ADDR_ANALOG_CTRL, 8'(ctrl_m));
      u_light_prox_host.wr(ADDR_PULSE_COUNT, 8'(pulse_m));
      chk("analog", {10'h000, analog_ctrl}, 16'(i * 21));
      rchk(ADDR_ANALOG_CTRL);
      rchk(ADDR_PULSE_COUNT);
    end
    for (int a = 8'h12; a <= 8'h20; a++) u_light_prox_host.wr(8'(a), seed[7:0]);
    rchk(ADDR_PART_ID);
    $display("test control done");
    near_irq_flag <= 1'b1;
    near_m = 1;
    ld();
    chk("busy", {15'h0000, prox_busy}, 16'h0000);
    repeat (4) @(posedge clock);
    rchk(ADDR_STATUS);
    {near_irq_flag, light_irq_flag} <= 2'b01;
    near_m = 0;
    light_m = 1;
    for (int a = 8'h14; a <= 8'h19; a++) begin
      if (a == 8'h16) rchk(ADDR_STATUS);
      rchk(8'(a));
      if (a[0] == 1'b0) ld();
      rchk(8'(a + 1));
      a++;
    end
    valid_clear <= 1'b1;
    @(posedge clock);
    valid_clear <= 1'b0;
    valid_m = 0;
    rchk(ADDR_STATUS);
    $display("test results done");
    pulse_m = 3;
    u_light_prox_host.wr(ADDR_PULSE_COUNT, 8'h03);
    prox_enable <= 1'b1;
    ld();
    {n, per, t0, pv} = '0;
    for (int i = 0; i < 2000 && prox_done !== 1'b1; i++) begin
      @(posedge clock);
      #1;
      if (led_pulse[0] === 1'b1 && pv == 0) begin
        if (n > 0) per = i - t0;
        t0 = i;
        n++;
      end
      pv = led_pulse[0];
    end
    chk("done", {15'h0000, prox_done}, 16'h0001);
    if (prox_done !== 1'b1) wrap_up();
    chk("pulses", 16'(n), 16'(pulse_m));
    chk("period", 16'(per), 16'(PULSE_PERIOD_CYC));
    $display("test pulses done");
    wrap_up();
  end
endmodule // light_prox_sensor_regs_tb_top
